// ==== rtl/mtc_calibration_control.sv ====
// Calibration command and status registers of the multi-turn counter.
// Assumes a byte register port and sensor events synchronous to clk.
`timescale 1ns/1ps
module mtc_calibration_control
    import mtc_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = ALIGN_TIMEOUT_CYCLES,
    parameter int COUNT_W = TURN_COUNT_W,
    parameter int STAT_LOG2 = PULSE_STAT_LOG2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Shaft sensing
    input wire logic revTick,
    input wire logic revClockwise,
    input wire logic magnetZero,
    input wire logic [15:0] wheelPosition,
    input wire logic pulseValid,
    input wire logic [7:0] pulseCode,
    // Compensation and fault sources
    input wire logic xcCompValid,
    input wire logic [15:0] xcCompIn,
    input wire logic [3:0] statusFault,
    input wire logic [6:0] encoderFault,
    input wire logic [1:0] turnFault,
    input wire logic [7:0] monitorFault,
    // Nonvolatile offset store
    input wire logic [15:0] nvRestoredOffset,
    output logic nvStoreStrobe,
    output logic [15:0] nvStoreData,
    // Mode
    output logic testMode
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    mtc_align_t state;
    logic wrCal, wrComp, wrTest, alarmClear, countClear, compClear, cwStart, ccwStart;
    logic cwEnable, ccwEnable, monTrigger, booted;
    logic cwDone, ccwDone, alignFail, captured, deviceReady, turnReady, resultReady;
    logic [1:0] revCnt;
    logic [31:0] timer;
    logic [15:0] firstCapture, alignOffset, xcComp;
    logic [COUNT_W-1:0] turnCount;
    logic [3:0] statusFlags;
    logic [6:0] encoderFlags;
    logic [1:0] turnFlags;
    logic [7:0] monitorFlags;
    logic [7:0] next_rdData;
    logic anyFault;
    logic [16:0] offsetSum;
    mtc_stat_if st ();

    assign wrCal = regWrite && regAddr == ADDR_CAL_CMD;
    assign wrComp = regWrite && regAddr == ADDR_COMP_MON_CMD;
    assign wrTest = regWrite && regAddr == ADDR_TEST_CTRL;
    assign alarmClear = regWrite && regAddr == ADDR_ALARM_CMD && regWrData[BIT_ALARM_CLEAR];
    assign countClear = wrCal && testMode && regWrData[BIT_COUNT_CLEAR];
    assign compClear = wrComp && regWrData[BIT_COMP_CLEAR];
    // Alignment commands are honoured only in counter test mode.
    assign cwStart = wrCal && testMode && state == AL_IDLE && regWrData[BIT_CW_ENABLE]
        && !regWrData[BIT_CCW_ENABLE];
    assign ccwStart = wrCal && testMode && state == AL_IDLE && regWrData[BIT_CW_ENABLE]
        && regWrData[BIT_CCW_ENABLE] && cwDone;
    assign anyFault = |{statusFault, encoderFault, turnFault, monitorFault};
    assign offsetSum = {1'b0, firstCapture} + {1'b0, wheelPosition};

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            testMode <= 1'b0;
            cwEnable <= 1'b0;
            ccwEnable <= 1'b0;
            monTrigger <= 1'b0;
        end else begin
            if (wrTest) begin
                testMode <= regWrData[BIT_TEST_MODE];
            end
            if (wrCal) begin
                cwEnable <= regWrData[BIT_CW_ENABLE];
                ccwEnable <= regWrData[BIT_CCW_ENABLE];
            end
            if (wrComp) begin
                monTrigger <= regWrData[BIT_MON_TRIGGER];
            end
        end
    end

    // ------------------------------------------------------------
    // Alignment sequencer
    // ------------------------------------------------------------
    // The timeout guards against a stalled shaft; it is looser than the host wait.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= AL_IDLE;
            revCnt <= 2'b00;
            timer <= 32'h0;
            captured <= 1'b0;
            firstCapture <= 16'h0000;
            cwDone <= 1'b0;
            ccwDone <= 1'b0;
            alignFail <= 1'b0;
            nvStoreStrobe <= 1'b0;
        end else begin
            nvStoreStrobe <= 1'b0;
            if (alarmClear) begin
                alignFail <= 1'b0;
            end
            case (state)
                AL_IDLE: begin
                    revCnt <= 2'b00;
                    timer <= 32'h0;
                    captured <= 1'b0;
                    if (cwStart) begin
                        state <= AL_CW;
                        cwDone <= 1'b0;
                        ccwDone <= 1'b0;
                        alignFail <= 1'b0;
                    end else if (ccwStart) begin
                        state <= AL_CCW;
                        ccwDone <= 1'b0;
                        alignFail <= 1'b0;
                    end
                end
                AL_CW, AL_CCW: begin
                    timer <= timer + 32'h1;
                    if (magnetZero && !captured) begin
                        captured <= 1'b1;
                        if (state == AL_CW) begin
                            firstCapture <= wheelPosition;
                        end
                    end
                    if (timer == 32'(TIMEOUT_CYCLES - 1)
                        || (revTick && revClockwise != (state == AL_CW))) begin
                        state <= AL_IDLE;
                        alignFail <= 1'b1;
                    end else if (revTick) begin
                        revCnt <= revCnt + 2'b01;
                        if (revCnt == 2'(ALIGN_REVS - 1)) begin
                            if (!captured) begin
                                state <= AL_IDLE;
                                alignFail <= 1'b1;
                            end else if (state == AL_CW) begin
                                state <= AL_IDLE;
                                cwDone <= 1'b1;
                            end else begin
                                state <= AL_STORE;
                                ccwDone <= 1'b1;
                            end
                        end
                    end
                end
                AL_STORE: begin
                    // The offset goes to nonvolatile memory with no host action.
                    nvStoreStrobe <= 1'b1;
                    state <= AL_IDLE;
                end
                default: begin
                    state <= AL_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Offset, turn count and compensation
    // ------------------------------------------------------------
    // The restored offset is taken one clock after reset release, never under reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            booted <= 1'b0;
            alignOffset <= 16'h0000;
        end else if (!booted) begin
            booted <= 1'b1;
            alignOffset <= nvRestoredOffset;
        end else if ((state == AL_CCW) && magnetZero && !captured) begin
            alignOffset <= offsetSum[16:1];
        end
    end
    assign nvStoreData = alignOffset;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            turnCount <= '0;
            turnReady <= 1'b0;
        end else begin
            turnReady <= booted;
            if (countClear) begin
                turnCount <= '0;
            end else if (revTick) begin
                turnCount <= revClockwise ? turnCount + 1'b1 : turnCount - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xcComp <= 16'h0000;
        end else if (xcCompValid) begin
            xcComp <= xcCompIn;
        end else if (compClear) begin
            xcComp <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Sticky faults and readiness
    // ------------------------------------------------------------
    // A fault arriving with the alarm clear survives it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusFlags <= 4'h0;
            encoderFlags <= 7'h00;
            turnFlags <= 2'h0;
            monitorFlags <= 8'h00;
            deviceReady <= 1'b0;
        end else begin
            if (alarmClear) begin
                statusFlags <= statusFault;
                encoderFlags <= encoderFault;
                turnFlags <= turnFault;
                monitorFlags <= monitorFault;
                deviceReady <= !anyFault;
            end else begin
                statusFlags <= statusFlags | statusFault;
                encoderFlags <= encoderFlags | encoderFault;
                turnFlags <= turnFlags | turnFault;
                monitorFlags <= monitorFlags | monitorFault;
                if (anyFault) begin
                    deviceReady <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pulse self-check
    // ------------------------------------------------------------
    assign st.run = monTrigger;
    assign st.sampleValid = pulseValid;
    assign st.sample = pulseCode;

    mtc_pulse_stat #(
        .LOG2N(STAT_LOG2)
    ) u_stat (
        .clk(clk),
        .rst(rst),
        .st(st)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resultReady <= 1'b0;
        end else if (st.done) begin
            resultReady <= 1'b1;
        end else if (wrComp && regWrData[BIT_MON_TRIGGER] && !monTrigger) begin
            resultReady <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        case (regAddr)
            ADDR_CAL_CMD: next_rdData = {4'h0, ccwEnable, cwEnable, 2'b00};
            ADDR_COMP_MON_CMD: next_rdData = {5'h00, monTrigger, 2'b00};
            ADDR_TEST_CTRL: next_rdData = {testMode, 7'h00};
            ADDR_ENC_ERR_LO: next_rdData = {3'h0, encoderFlags[4:0]};
            ADDR_ENC_ERR_HI: next_rdData = {6'h00, encoderFlags[6:5]};
            ADDR_CAL_STATUS: next_rdData = {statusFlags[3], state != AL_IDLE, ccwDone,
                cwDone, statusFlags[2:1], alignFail, statusFlags[0]};
            ADDR_TURN_COUNT: next_rdData = 8'({1'b0, turnCount[COUNT_W-1:32]});
            ADDR_TURN_COUNT + 8'h01: next_rdData = turnCount[31:24];
            ADDR_TURN_COUNT + 8'h02: next_rdData = turnCount[23:16];
            ADDR_TURN_COUNT + 8'h03: next_rdData = turnCount[15:8];
            ADDR_TURN_COUNT + 8'h04: next_rdData = turnCount[7:0];
            ADDR_OFFSET_HI: next_rdData = alignOffset[15:8];
            ADDR_OFFSET_LO: next_rdData = alignOffset[7:0];
            ADDR_COMP_HI: next_rdData = xcComp[15:8];
            ADDR_COMP_LO: next_rdData = xcComp[7:0];
            ADDR_TURN_ERR: next_rdData = {6'h00, turnFlags};
            ADDR_MON_ERR: next_rdData = monitorFlags;
            ADDR_ALARM_READY: next_rdData = {anyFlag(), 2'b00, deviceReady, 4'h0};
            ADDR_RESULT_READY: next_rdData = {4'h0, resultReady, ccwDone, cwDone, turnReady};
            ADDR_PULSE_LOW: next_rdData = st.lowBound;
            ADDR_PULSE_MEAN: next_rdData = st.mean;
            default: next_rdData = REG_RESET;
        endcase
    end

    function automatic logic anyFlag();
        anyFlag = |{statusFlags, encoderFlags, turnFlags, monitorFlags};
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= REG_RESET;
        end else if (regRead) begin
            regRdData <= next_rdData;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_cw_done_alone: assert property ($rose(cwDone) |-> !ccwDone && !alignFail)
        else $error("clockwise done with other flags set");
    a_ccw_both_done: assert property ($rose(ccwDone) |-> cwDone && state == AL_STORE)
        else $error("counter-clockwise done without clockwise done");
    a_offset_stored: assert property ($rose(ccwDone) |=> nvStoreStrobe
        && nvStoreData == $past(alignOffset, 1))
        else $error("offset not stored after alignment");
    a_count_cleared: assert property (countClear |=> turnCount == '0)
        else $error("turn count not cleared");
    a_comp_cleared: assert property (compClear && !xcCompValid |=> xcComp == 16'h0000)
        else $error("compensation not cleared");
    a_alarm_clean: assert property (alarmClear && !anyFault
        |=> turnFlags == 2'h0 && monitorFlags == 8'h00)
        else $error("error bytes not cleared");
    a_ready_after_clear: assert property (alarmClear && !anyFault && booted
        ##1 !anyFault |=> deviceReady && turnReady && encoderFlags == 7'h00)
        else $error("ready bytes wrong after alarm clear");
    a_check_restart: assert property ($rose(monTrigger) && !st.done |-> ##0 1'b1 ##1
        !resultReady)
        else $error("result flag survives self-check start");
    a_result_flag: assert property (st.done |=> resultReady)
        else $error("result ready not set");
    a_mean_readout: assert property (regRead && regAddr == ADDR_PULSE_MEAN
        |=> regRdData == $past(st.mean, 1))
        else $error("mean readout wrong");
    a_mode_gate: assert property (wrCal && !testMode && state == AL_IDLE
        |=> state == AL_IDLE)
        else $error("command taken outside test mode");
    a_busy_held: assert property (cwStart |=> state == AL_CW [*2] or ##1 state == AL_IDLE)
        else $error("busy not held during alignment");

    c_cw_align: cover property (state == AL_CW ##[1:1000] cwDone);
    c_full_align: cover property (nvStoreStrobe);
    c_align_fail: cover property ($rose(alignFail));
    c_self_check: cover property ($rose(resultReady));
endmodule

// ==== rtl/mtc_pkg.sv ====
// Constants, register map and types of the multi-turn calibration control block.
// Assumes a byte-wide register port driven synchronously to the encoder clock.
package mtc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ALARM_CMD = 8'h02;
    localparam logic [7:0] ADDR_CAL_CMD = 8'h06;
    localparam logic [7:0] ADDR_COMP_MON_CMD = 8'h08;
    localparam logic [7:0] ADDR_TEST_CTRL = 8'h0a;
    localparam logic [7:0] ADDR_ENC_ERR_LO = 8'h22;
    localparam logic [7:0] ADDR_ENC_ERR_HI = 8'h23;
    localparam logic [7:0] ADDR_CAL_STATUS = 8'h2b;
    localparam logic [7:0] ADDR_TURN_COUNT = 8'h30;
    localparam logic [7:0] ADDR_OFFSET_HI = 8'h3e;
    localparam logic [7:0] ADDR_OFFSET_LO = 8'h3f;
    localparam logic [7:0] ADDR_COMP_HI = 8'h40;
    localparam logic [7:0] ADDR_COMP_LO = 8'h41;
    localparam logic [7:0] ADDR_TURN_ERR = 8'h42;
    localparam logic [7:0] ADDR_MON_ERR = 8'h43;
    localparam logic [7:0] ADDR_ALARM_READY = 8'h44;
    localparam logic [7:0] ADDR_RESULT_READY = 8'h45;
    localparam logic [7:0] ADDR_PULSE_LOW = 8'h46;
    localparam logic [7:0] ADDR_PULSE_MEAN = 8'h47;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_ALARM_CLEAR = 2;
    localparam int BIT_COUNT_CLEAR = 1;
    localparam int BIT_CW_ENABLE = 2;
    localparam int BIT_CCW_ENABLE = 3;
    localparam int BIT_COMP_CLEAR = 0;
    localparam int BIT_MON_TRIGGER = 2;
    localparam int BIT_TEST_MODE = 7;
    localparam int BIT_DEVICE_READY = 4;
    localparam int BIT_ALARM_TRIGGER = 7;
    // ------------------------------------------------------------
    // Reset values, widths and timing
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int TURN_COUNT_W = 39;
    localparam int ALIGN_REVS = 2;
    localparam int PULSE_STAT_LOG2 = 8;
    localparam int CLK_HZ = 100_000_000;
    localparam int ALIGN_TIMEOUT_MS = 2400;
    localparam int ALIGN_TIMEOUT_CYCLES = ALIGN_TIMEOUT_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        AL_IDLE = 2'b00,
        AL_CW = 2'b01,
        AL_CCW = 2'b10,
        AL_STORE = 2'b11
    } mtc_align_t;
endpackage

// ==== rtl/mtc_stat_if.sv ====
// Link between the calibration registers and the pulse statistics engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mtc_stat_if;
    logic run;
    logic sampleValid;
    logic [7:0] sample;
    logic done;
    logic [7:0] lowBound;
    logic [7:0] mean;
    modport ctrl (output run, output sampleValid, output sample,
        input done, input lowBound, input mean);
    modport engine (input run, input sampleValid, input sample,
        output done, output lowBound, output mean);
endinterface

// ==== rtl/mtc_pulse_stat.sv ====
// Pulse level statistics: window mean, then mean absolute deviation.
// Assumes samples arrive only while the shaft turns.
`timescale 1ns/1ps
module mtc_pulse_stat
    import mtc_pkg::*;
#(
    parameter int LOG2N = PULSE_STAT_LOG2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Statistics link
    mtc_stat_if.engine st
);
    // ------------------------------------------------------------
    // Two passes
    // ------------------------------------------------------------
    // Sigma is taken as 1.25 times the mean deviation, so four sigma is five deviations;
    // this avoids a square root at the cost of a small bias for skewed data.
    logic runSeen;
    logic phase;
    logic finished;
    logic [LOG2N-1:0] cnt;
    logic [LOG2N+7:0] acc;
    logic [7:0] dev;
    logic [10:0] fiveDev;

    assign dev = (st.sample > st.mean) ? st.sample - st.mean : st.mean - st.sample;
    assign fiveDev = 11'(((acc + dev) >> LOG2N) * 5);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runSeen <= 1'b0;
            phase <= 1'b0;
            finished <= 1'b0;
            cnt <= '0;
            acc <= '0;
            st.done <= 1'b0;
            st.mean <= 8'h00;
            st.lowBound <= 8'h00;
        end else begin
            runSeen <= st.run;
            st.done <= 1'b0;
            if (st.run && !runSeen) begin
                phase <= 1'b0;
                finished <= 1'b0;
                cnt <= '0;
                acc <= '0;
            end else if (st.run && st.sampleValid && !finished) begin
                cnt <= cnt + 1'b1;
                acc <= acc + (phase ? {{LOG2N{1'b0}}, dev} : {{LOG2N{1'b0}}, st.sample});
                if (&cnt) begin
                    acc <= '0;
                    if (!phase) begin
                        phase <= 1'b1;
                        st.mean <= 8'((acc + st.sample) >> LOG2N);
                    end else begin
                        finished <= 1'b1;
                        st.done <= 1'b1;
                        st.lowBound <= (fiveDev >= {3'h0, st.mean}) ? 8'h00
                            : 8'({3'h0, st.mean} - fiveDev);
                    end
                end
            end
        end
    end
endmodule

// ==== tb/mtc_shaft_model.sv ====
// Shaft and harvested pulse sensor stand-in for the calibration block.
// Assumes the bench drives spin, direction and pulse enable off the clock edge.
`timescale 1ns/1ps
module mtc_shaft_model #(
    parameter int REV = 100,
    parameter logic [15:0] POS = 16'h1234,
    parameter logic [7:0] CODE = 8'h50
) (
    // Clock, reset and motion
    input wire logic clk,
    input wire logic rst,
    input wire logic spin,
    input wire logic cw,
    input wire logic pulseOn,
    // Sensor events
    output logic revTick,
    output logic revClockwise,
    output logic magnetZero,
    output logic [15:0] wheelPosition,
    output logic pulseValid,
    output logic [7:0] pulseCode
);
    int cnt;
    // Phase restarts with each spin, so magnet zero always comes before the first tick.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt <= 0;
        else if (!spin) cnt <= 0;
        else cnt <= (cnt == REV - 1) ? 0 : cnt + 1;
    end
    assign revTick = spin && cnt == REV - 1;
    assign revClockwise = cw;
    assign magnetZero = spin && cnt == REV / 2;
    // Position is valid only at the zero pulse; the inverse elsewhere exposes late capture.
    assign wheelPosition = magnetZero ? POS : ~POS;
    assign pulseValid = pulseOn && cnt % 4 == 3;
    assign pulseCode = pulseValid ? CODE + {4'h0, cnt[2], 3'b000} : ~CODE;
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench of the calibration block driven through its register port.
// Assumes the shaft model as far side and scaled timeout and statistics lengths.
`timescale 1ns/1ps
module tb_top;
    import mtc_pkg::*;
    logic clk, rst, regWrite, regRead, xcCompValid, spin, cw, pulseOn;
    logic revTick, revClockwise, magnetZero, pulseValid, nvStoreStrobe, testMode;
    logic [7:0] regAddr, regWrData, regRdData, monitorFault, pulseCode, v;
    logic [15:0] xcCompIn, wheelPosition, nvStoreData;
    logic [6:0] encoderFault;
    logic [1:0] turnFault;
    logic [15:0] nvMem = 16'h0000;
    logic [7:0] alAddr [6] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h22, 8'h23};
    logic [7:0] alExp [6] = '{8'h00, 8'h00, 8'h10, 8'h01, 8'h00, 8'h00};
    int miscompares, total_checks, stores;
    mtc_shaft_model shaft (.clk(clk), .rst(rst), .spin(spin), .cw(cw), .pulseOn(pulseOn),
        .revTick(revTick), .revClockwise(revClockwise), .magnetZero(magnetZero),
        .wheelPosition(wheelPosition), .pulseValid(pulseValid), .pulseCode(pulseCode));
    mtc_calibration_control #(.TIMEOUT_CYCLES(2000), .STAT_LOG2(2)) dut (.clk(clk), .rst(rst),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .revTick(revTick), .revClockwise(revClockwise),
        .magnetZero(magnetZero), .wheelPosition(wheelPosition), .pulseValid(pulseValid),
        .pulseCode(pulseCode), .xcCompValid(xcCompValid), .xcCompIn(xcCompIn),
        .statusFault(4'h0), .encoderFault(encoderFault), .turnFault(turnFault),
        .monitorFault(monitorFault), .nvRestoredOffset(nvMem),
        .nvStoreStrobe(nvStoreStrobe), .nvStoreData(nvStoreData), .testMode(testMode));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (nvStoreStrobe === 1'b1) begin
            stores++;
            nvMem <= nvStoreData;
        end
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        d = regRdData;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] got;
        rd(a, got);
        chk($sformatf("reg %h", a), got, e);
    endtask
    task automatic turn(input logic dir, input int n);
        cw = dir;
        spin = 1'b1;
        repeat (n) @(negedge clk);
        spin = 1'b0;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #300us;
        miscompares++;
        give_verdict();
    end
    initial begin
        {rst, regWrite, regRead, xcCompValid, spin, cw, pulseOn} = 7'h40;
        {regAddr, regWrData, monitorFault, xcCompIn, encoderFault, turnFault} = '0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        wr(8'h0f, 8'h0f);
        wr(ADDR_TEST_CTRL, 8'h80);
        chk("testMode", {7'h00, testMode}, 8'h01);
        rdc(8'h0f, 8'h00);
        {encoderFault, turnFault, monitorFault} = {7'h41, 2'h2, 8'h01};
        @(negedge clk);
        {encoderFault, turnFault, monitorFault} = '0;
        rdc(ADDR_MON_ERR, 8'h01);
        rdc(ADDR_TURN_ERR, 8'h02);
        rdc(ADDR_ENC_ERR_LO, 8'h01);
        rdc(ADDR_ENC_ERR_HI, 8'h02);
        rdc(ADDR_ALARM_READY, 8'h80);
        wr(ADDR_ALARM_CMD, 8'h04);
        foreach (alAddr[i]) rdc(alAddr[i], alExp[i]);
        wr(ADDR_CAL_CMD, 8'h04);
        rdc(ADDR_CAL_STATUS, 8'h40);
        turn(1'b1, 210);
        rdc(ADDR_CAL_STATUS, 8'h10);
        wr(ADDR_CAL_CMD, 8'h0c);
        turn(1'b0, 215);
        rdc(ADDR_CAL_STATUS, 8'h30);
        chk("stores", stores[7:0], 8'h01);
        rdc(ADDR_OFFSET_HI, 8'h12);
        rdc(ADDR_OFFSET_LO, 8'h34);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rdc(ADDR_OFFSET_HI, 8'h12);
        rdc(ADDR_OFFSET_LO, 8'h34);
        wr(ADDR_TEST_CTRL, 8'h80);
        turn(1'b1, 105);
        rdc(ADDR_TURN_COUNT + 8'h04, 8'h01);
        wr(ADDR_CAL_CMD, 8'h02);
        for (int i = 0; i < 5; i++) rdc(ADDR_TURN_COUNT + 8'(i), 8'h00);
        xcCompIn = 16'hbeef;
        xcCompValid = 1'b1;
        @(negedge clk);
        xcCompValid = 1'b0;
        rdc(ADDR_COMP_HI, 8'hbe);
        wr(ADDR_COMP_MON_CMD, 8'h01);
        rdc(ADDR_COMP_HI, 8'h00);
        rdc(ADDR_COMP_LO, 8'h00);
        for (int d = 1; d >= 0; d--) begin
            {cw, spin, pulseOn} = {d[0], 2'b11};
            wr(ADDR_COMP_MON_CMD, 8'h04);
            rdc(ADDR_RESULT_READY, 8'h01);
            v = '0;
            for (int n = 0; n < 100 && v[3] !== 1'b1; n++) rd(ADDR_RESULT_READY, v);
            chk("result ready", v & 8'h08, 8'h08);
            wr(ADDR_COMP_MON_CMD, 8'h00);
            {spin, pulseOn} = 2'b00;
            rdc(ADDR_PULSE_LOW, 8'h40);
            rdc(ADDR_PULSE_MEAN, 8'h54);
        end
        wr(ADDR_TEST_CTRL, 8'h00);
        chk("testMode", {7'h00, testMode}, 8'h00);
        give_verdict();
    end
endmodule
